// ---- hdl/stm_timer.sv ----
// 16-bit timer/counter with oscillator pins, compare reset and Avalon-MM registers
module stm_timer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // core timing and power state
   input wire logic instr_cycle,
   input wire logic sleep,
   // port c pins 0 (external clock / osc out) and 1 (osc in)
   input wire logic [1:0] port_c_direction,
   input wire logic [1:0] port_c_out,
   input wire logic [1:0] port_c_in,
   output logic [1:0] port_c_pin_out,
   output logic [1:0] port_c_pin_oe,
   output logic osc_run,
   // compare unit and converter
   input wire logic adc_enable,
   output logic adc_start,
   // interrupt
   output logic irq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   stm_pkg::stm_ctl_t ctl, next_ctl;
   logic [15:0] count, next_count;
   logic [15:0] cmp, next_cmp;
   logic [3:0] cmp_mode, next_cmp_mode;
   logic [7:0] intctl, next_intctl;
   logic ovf_flag, next_ovf_flag;
   logic ovf_en, next_ovf_en;
   logic [31:0] rdata, next_rdata;
   logic ack, next_ack;
   logic [1:0] resp, next_resp;
   logic adc_go, next_adc_go;

   stm_pkg::stm_ext_t ext;
   logic raw_tick;
   logic tick;
   logic wr;
   logic rd;
   logic hit;
   logic wr_lo;
   logic wr_hi;
   logic special;
   logic match;
   logic [7:0] wbyte;

   // ----------------------------------------
   // count clock
   // ----------------------------------------
   stm_edge u_edge (
      .ref_clk(ref_clk),
      .rst(rst),
      .sync_bypass(ctl.sync_bypass),
      .clk_pin(port_c_in[0]),
      .ext(ext)
   );

   // instruction cycles stop in sleep; external edges keep counting
   always_comb begin
      if (ctl.clock_source_select) begin
         raw_tick = ctl.timer_on & ext.ext_rise;
      end else begin
         raw_tick = ctl.timer_on & instr_cycle & ~sleep;
      end
   end

   stm_prescale u_pre (
      .ref_clk(ref_clk),
      .rst(rst),
      .prescale_select(ctl.prescale_select),
      .clear(wr_lo | wr_hi),
      .tick_in(raw_tick),
      .tick_out(tick)
   );

   // ----------------------------------------
   // oscillator pins
   // ----------------------------------------
   always_comb begin
      osc_run = ctl.osc_enable;
      port_c_pin_out = port_c_out;
      // oscillator mode releases port drive on both pins
      port_c_pin_oe = ctl.osc_enable ? 2'b00 : ~port_c_direction;
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   always_comb begin
      wr = avs_write & ~ack;
      rd = avs_read & ~ack;
      wbyte = avs_writedata[7:0];
      unique case (avs_address)
         stm_pkg::ADDR_INTCTL, stm_pkg::ADDR_PIFLAGS, stm_pkg::ADDR_CNT_LO,
         stm_pkg::ADDR_CNT_HI, stm_pkg::ADDR_TCTL, stm_pkg::ADDR_PIENS,
         stm_pkg::ADDR_CMP_LO, stm_pkg::ADDR_CMP_HI, stm_pkg::ADDR_CMP_MODE: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      wr_lo = wr & avs_byteenable[0] & (avs_address == stm_pkg::ADDR_CNT_LO);
      wr_hi = wr & avs_byteenable[0] & (avs_address == stm_pkg::ADDR_CNT_HI);
      avs_waitrequest = (avs_read | avs_write) & ~ack;
      avs_readdata = rdata;
      avs_response = resp;
   end

   // ----------------------------------------
   // counter, compare and flags
   // ----------------------------------------
   always_comb begin
      special = (cmp_mode == stm_pkg::CMP_MODE_SPECIAL);
      match = special & (count == cmp);
      next_count = count;
      next_ovf_flag = ovf_flag;
      next_adc_go = match & adc_enable;
      // software clear first, so a same-cycle overflow still sets the flag
      if (wr & avs_byteenable[0] & (avs_address == stm_pkg::ADDR_PIFLAGS)) begin
         next_ovf_flag = wbyte[stm_pkg::OVF_BIT];
      end
      if (match) begin
         next_count = stm_pkg::CNT_RST;
      end else if (tick) begin
         next_count = count + 16'h0001;
         if (count == stm_pkg::CNT_MAX) begin
            next_ovf_flag = 1'b1;
         end
      end
      // a bus write beats the compare clear
      if (wr_lo) begin
         next_count = {count[15:8], wbyte};
      end
      if (wr_hi) begin
         next_count = {wbyte, count[7:0]};
      end
      irq = ovf_flag & ovf_en & intctl[stm_pkg::INTCTL_PERIPHERAL_IRQ_ENABLE_BIT]
         & intctl[stm_pkg::INTCTL_GIE_BIT];
      adc_start = adc_go;
   end

   // ----------------------------------------
   // register writes and reads
   // ----------------------------------------
   always_comb begin
      next_ctl = ctl;
      next_cmp = cmp;
      next_cmp_mode = cmp_mode;
      next_intctl = intctl;
      next_ovf_en = ovf_en;
      next_rdata = rdata;
      next_resp = resp;
      next_ack = (avs_read | avs_write) & ~ack;
      if (wr & avs_byteenable[0]) begin
         unique case (avs_address)
            stm_pkg::ADDR_TCTL: next_ctl = stm_pkg::stm_ctl_t'(wbyte[5:0]);
            stm_pkg::ADDR_INTCTL: next_intctl = wbyte;
            stm_pkg::ADDR_PIENS: next_ovf_en = wbyte[stm_pkg::OVF_BIT];
            stm_pkg::ADDR_CMP_LO: next_cmp = {cmp[15:8], wbyte};
            stm_pkg::ADDR_CMP_HI: next_cmp = {wbyte, cmp[7:0]};
            stm_pkg::ADDR_CMP_MODE: next_cmp_mode = wbyte[3:0];
            default: next_cmp_mode = cmp_mode;
         endcase
      end
      if (rd | wr) begin
         next_resp = hit ? 2'h0 : 2'h2;
      end
      if (rd) begin
         unique case (avs_address)
            stm_pkg::ADDR_INTCTL: next_rdata = {24'h000000, intctl};
            stm_pkg::ADDR_PIFLAGS: next_rdata = {31'h00000000, ovf_flag};
            stm_pkg::ADDR_CNT_LO: next_rdata = {24'h000000, count[7:0]};
            stm_pkg::ADDR_CNT_HI: next_rdata = {24'h000000, count[15:8]};
            stm_pkg::ADDR_TCTL: next_rdata = {26'h0000000, ctl};
            stm_pkg::ADDR_PIENS: next_rdata = {31'h00000000, ovf_en};
            stm_pkg::ADDR_CMP_LO: next_rdata = {24'h000000, cmp[7:0]};
            stm_pkg::ADDR_CMP_HI: next_rdata = {24'h000000, cmp[15:8]};
            stm_pkg::ADDR_CMP_MODE: next_rdata = {28'h0000000, cmp_mode};
            default: next_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctl <= stm_pkg::stm_ctl_t'(stm_pkg::TCTL_RST[5:0]);
         count <= stm_pkg::CNT_RST;
         cmp <= stm_pkg::CMP_RST;
         cmp_mode <= stm_pkg::CMP_MODE_RST;
         intctl <= stm_pkg::INTCTL_RST;
         ovf_flag <= stm_pkg::PIFLAGS_RST[0];
         ovf_en <= stm_pkg::PIENS_RST[0];
         rdata <= 32'h00000000;
         ack <= 1'b0;
         resp <= 2'h0;
         adc_go <= 1'b0;
      end else begin
         ctl <= next_ctl;
         count <= next_count;
         cmp <= next_cmp;
         cmp_mode <= next_cmp_mode;
         intctl <= next_intctl;
         ovf_flag <= next_ovf_flag;
         ovf_en <= next_ovf_en;
         rdata <= next_rdata;
         ack <= next_ack;
         resp <= next_resp;
         adc_go <= next_adc_go;
      end
   end
endmodule // stm_timer

// ---- inc/stm_pkg.sv ----
// package: register map, field positions, reset values and types of the 16-bit timer
package stm_pkg;
   // register offsets (byte addresses are four times these indices)
   localparam logic [7:0] ADDR_INTCTL = 8'h0b;
   localparam logic [7:0] ADDR_PIFLAGS = 8'h0c;
   localparam logic [7:0] ADDR_CNT_LO = 8'h0e;
   localparam logic [7:0] ADDR_CNT_HI = 8'h0f;
   localparam logic [7:0] ADDR_TCTL = 8'h10;
   localparam logic [7:0] ADDR_PIENS = 8'h8c;
   // own registers: compare value and compare mode
   localparam logic [7:0] ADDR_CMP_LO = 8'h15;
   localparam logic [7:0] ADDR_CMP_HI = 8'h16;
   localparam logic [7:0] ADDR_CMP_MODE = 8'h17;
   // timer control fields
   localparam int TCTL_ON_BIT = 0;
   localparam int TCTL_CS_BIT = 1;
   localparam int TCTL_SYNC_BIT = 2;
   localparam int TCTL_OSC_BIT = 3;
   localparam int TCTL_PS_LSB = 4;
   localparam logic [7:0] TCTL_MASK = 8'h3f;
   // interrupt control fields
   localparam int INTCTL_GIE_BIT = 7;
   localparam int INTCTL_PERIPHERAL_IRQ_ENABLE_BIT = 6;
   // flag / enable bit of the overflow
   localparam int OVF_BIT = 0;
   // reset values
   localparam logic [7:0] TCTL_RST = 8'h00;
   localparam logic [7:0] PIFLAGS_RST = 8'h00;
   localparam logic [7:0] PIENS_RST = 8'h00;
   localparam logic [7:0] INTCTL_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CMP_RST = 16'hffff;
   localparam logic [3:0] CMP_MODE_RST = 4'h0;
   // compare mode that clears the count on match
   localparam logic [3:0] CMP_MODE_SPECIAL = 4'hb;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   // oscillator ratings
   localparam int OSC_MAX_KHZ = 200;
   localparam int OSC_NOM_KHZ = 32;
   // timer control register fields
   typedef struct packed {
      logic [1:0] prescale_select;
      logic osc_enable;
      logic sync_bypass;
      logic clock_source_select;
      logic timer_on;
   } stm_ctl_t;
   // one count-clock event plus the pin level
   typedef struct packed {
      logic ext_rise;
      logic ext_level;
   } stm_ext_t;
endpackage : stm_pkg

// ---- hdl/stm_edge.sv ----
// external clock edge detector with optional two-stage synchroniser
module stm_edge (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic sync_bypass,
   // pin and result
   input wire logic clk_pin,
   output stm_pkg::stm_ext_t ext
);
   logic meta;
   logic sync;
   logic last;
   logic next_last;
   logic sel;

   // ----------------------------------------
   // synchroniser
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= clk_pin;
         sync <= meta;
         last <= next_last;
      end
   end

   // bypass takes the pin directly, sync takes the second stage
   always_comb begin
      sel = sync_bypass ? clk_pin : sync;
      next_last = sel;
      ext.ext_level = sel;
      ext.ext_rise = sel & ~last;
   end
endmodule // stm_edge

// ---- hdl/stm_prescale.sv ----
// count clock prescaler: divides count events by 1, 2, 4 or 8
module stm_prescale (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic [1:0] prescale_select,
   input wire logic clear,
   // events
   input wire logic tick_in,
   output logic tick_out
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [2:0] lim;

   // ----------------------------------------
   // divide
   // ----------------------------------------
   always_comb begin
      lim = 3'((4'h1 << prescale_select) - 4'h1);
      next_cnt = cnt;
      tick_out = 1'b0;
      if (clear) begin
         next_cnt = 3'h0;
      end else if (tick_in) begin
         if (cnt >= lim) begin
            next_cnt = 3'h0;
            tick_out = 1'b1;
         end else begin
            next_cnt = cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= 3'h0;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule // stm_prescale

// ---- verif/stm_clk_src.sv ----
// external clock source model driving the counter input pin
module stm_clk_src #(
   parameter int HALF_NS = 37
) (
   // control
   input wire logic enable,
   // pin and count of rising edges made
   output logic clk_pin,
   output int edges
);
   timeunit 1ns;
   timeprecision 1ps;
   // stands low outside bursts; each period is finished whole
   // a burst starts off the clock grid so no pin edge meets a sampling edge
   initial begin
      clk_pin = 1'b0;
      edges = 0;
      forever begin
         if (!enable) begin
            wait (enable);
            #0.75;
         end
         #HALF_NS clk_pin = 1'b1;
         edges++;
         #HALF_NS clk_pin = 1'b0;
      end
   end
endmodule // stm_clk_src

// ---- verif/stm_timer_monitor.sv ----
// checker: bus handshake, pin ownership, oscillator and compare pulse
module stm_timer_monitor (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   // pins and core
   input wire logic sleep,
   input wire logic [1:0] port_c_direction,
   input wire logic [1:0] port_c_pin_oe,
   input wire logic osc_run,
   input wire logic adc_enable,
   input wire logic adc_start
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic mapped;
   assign mapped = avs_address inside {8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h8c, 8'h15, 8'h16, 8'h17};
   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_rd_done;
      avs_read && !avs_waitrequest;
   endsequence
   a_one_wait: assert property (s_req_wait |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   a_read_steps: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read handshake out of step");
   a_unmapped_err: assert property (s_rd_done ##0 !mapped |-> avs_response == 2'b10 && avs_readdata == 32'h0)
      else $error("unmapped read not refused");
   a_mapped_ok: assert property (s_rd_done ##0 mapped |-> avs_response == 2'b00)
      else $error("mapped read refused");
   a_osc_pins_free: assert property (osc_run |-> port_c_pin_oe == 2'b00)
      else $error("pins driven while oscillator runs");
   a_port_owns_pins: assert property (!osc_run |-> port_c_pin_oe == ~port_c_direction)
      else $error("pin enables ignore direction");
   a_sleep_osc: assert property (sleep && !avs_write |=> $stable(osc_run))
      else $error("oscillator changed in sleep");
   a_adc_pulse: assert property (adc_start |=> !adc_start)
      else $error("conversion start longer than one cycle");
   a_adc_gate: assert property (adc_start |-> $past(adc_enable))
      else $error("conversion start with converter off");
endmodule // stm_timer_monitor

bind stm_timer stm_timer_monitor u_mon (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .avs_response, .sleep, .port_c_direction, .port_c_pin_oe,
   .osc_run, .adc_enable, .adc_start);

// ---- verif/stm_timer_tb.sv ----
// testbench: registers, counting, overflow, prescale, external clock, compare reset
module stm_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic instr_cycle = 1'b0;
   logic sleep = 1'b0;
   logic adc_enable = 1'b0;
   logic ext_run = 1'b0;
   logic [1:0] port_dir = 2'b11;
   logic ext_clk;
   logic [1:0] pin_oe;
   logic osc_run;
   logic adc_start;
   logic irq;
   int ext_edges;
   int adc_pulses = 0;
   int miscompares = 0;
   int comparisons = 0;
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (adc_start === 1'b1) adc_pulses <= adc_pulses + 1;
   stm_timer DUT (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .avs_response, .instr_cycle,
      .sleep, .port_c_direction(port_dir), .port_c_out(2'b00), .port_c_in({1'b0, ext_clk}),
      .port_c_pin_out(), .port_c_pin_oe(pin_oe), .osc_run, .adc_enable, .adc_start, .irq);
   stm_clk_src SRC (.enable(ext_run), .clk_pin(ext_clk), .edges(ext_edges));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      avs_address <= a;
      avs_writedata <= {24'h0, v};
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      v = avs_readdata[7:0];
      avs_read <= 1'b0;
      @(posedge ref_clk);
      chk8(v, exp);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         instr_cycle <= 1'b1;
         @(posedge ref_clk);
         instr_cycle <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task automatic conclude();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      #100us;
      miscompares++;
      conclude();
   end
   initial begin
      int e0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rdc(stm_pkg::ADDR_TCTL, 8'h00);
      rdc(stm_pkg::ADDR_PIFLAGS, 8'h00);
      rdc(stm_pkg::ADDR_PIENS, 8'h00);
      rdc(8'h20, 8'h00);
      port_dir <= 2'b01;
      @(posedge ref_clk);
      chk8({6'h0, pin_oe}, 8'h02);
      wr(stm_pkg::ADDR_TCTL, 8'hf8);
      repeat (20) @(posedge ref_clk);
      rdc(stm_pkg::ADDR_TCTL, 8'h38);
      chk8({6'h0, pin_oe}, 8'h00);
      sleep <= 1'b1;
      ticks(4);
      chk1(osc_run, 1'b1);
      wr(stm_pkg::ADDR_TCTL, 8'h01);
      chk8({6'h0, pin_oe}, 8'h02);
      port_dir <= 2'b11;
      rdc(stm_pkg::ADDR_CNT_LO, 8'h00);
      sleep <= 1'b0;
      wr(stm_pkg::ADDR_TCTL, 8'h00);
      wr(stm_pkg::ADDR_CNT_LO, 8'h34);
      wr(stm_pkg::ADDR_CNT_HI, 8'h12);
      ticks(3);
      rdc(stm_pkg::ADDR_CNT_LO, 8'h34);
      rdc(stm_pkg::ADDR_CNT_HI, 8'h12);
      wr(stm_pkg::ADDR_TCTL, 8'h01);
      wr(stm_pkg::ADDR_CNT_HI, 8'hff);
      wr(stm_pkg::ADDR_CNT_LO, 8'hfe);
      ticks(1);
      rdc(stm_pkg::ADDR_CNT_LO, 8'hff);
      rdc(stm_pkg::ADDR_PIFLAGS, 8'h00);
      ticks(1);
      rdc(stm_pkg::ADDR_CNT_HI, 8'h00);
      rdc(stm_pkg::ADDR_PIFLAGS, 8'h01);
      wr(stm_pkg::ADDR_INTCTL, 8'hc0);
      chk1(irq, 1'b0);
      wr(stm_pkg::ADDR_PIENS, 8'h01);
      chk1(irq, 1'b1);
      wr(stm_pkg::ADDR_PIFLAGS, 8'h00);
      chk1(irq, 1'b0);
      for (int p = 0; p < 4; p++) begin
         wr(stm_pkg::ADDR_TCTL, 8'(p * 16 + 1));
         wr(stm_pkg::ADDR_CNT_LO, 8'h00);
         ticks(8);
         rdc(stm_pkg::ADDR_CNT_LO, 8'(8 >> p));
      end
      for (int s = 0; s < 2; s++) begin
         wr(stm_pkg::ADDR_TCTL, 8'(s * 4 + 3));
         wr(stm_pkg::ADDR_CNT_LO, 8'h00);
         e0 = ext_edges;
         ext_run <= 1'b1;
         repeat (300) @(posedge ref_clk);
         ext_run <= 1'b0;
         repeat (40) @(posedge ref_clk);
         rdc(stm_pkg::ADDR_CNT_LO, 8'(ext_edges - e0));
      end
      wr(stm_pkg::ADDR_TCTL, 8'h01);
      adc_enable <= 1'b1;
      wr(stm_pkg::ADDR_CMP_LO, 8'h05);
      wr(stm_pkg::ADDR_CMP_HI, 8'h00);
      wr(stm_pkg::ADDR_CNT_LO, 8'h00);
      wr(stm_pkg::ADDR_CMP_MODE, 8'h0b);
      ticks(5);
      rdc(stm_pkg::ADDR_CNT_LO, 8'h00);
      chk8(8'(adc_pulses), 8'h01);
      ticks(7);
      rdc(stm_pkg::ADDR_CNT_LO, 8'h02);
      rdc(stm_pkg::ADDR_PIFLAGS, 8'h00);
      chk8(8'(adc_pulses), 8'h02);
      conclude();
   end
endmodule // stm_timer_tb
